// file: rtl/asrx_pkg.sv
// Constants, field positions and state codes of the serial receiver.
// Assumes a single bus clock and an APB register port with 32-bit data.
// Function
// - High divisor write is buffered; low divisor write loads all 13 bits.
// - A zero divisor stops the baud generator completely.
// - Divisor 1 to 8191 gives baud rate of bus clock over 16 times divisor.
// - Low divisor resets non-zero; generator idles until rx or tx first enabled.
// - Full flag sets on character transfer; 8-bit: status then data read clears.
// - 9-bit mode: full clears after status, data and control three reads.
// - Idle flag sets after line high one character time, 10 or 11 bits.
// - Idle select low: idle counting starts right after the start bit.
// - Idle select high: idle counting starts only after the stop bit.
// - Idle clears by status then data read; sets once per received character.
// - New character while previous unread is discarded; sets overrun unless framing error set.
// - Any disagreeing sample in start, data or stop bit sets noise flag.
// - Low stop bit sets framing error together with full flag.
// - Enabled parity mismatch sets parity error together with full flag.
// - Noise, framing and parity flags clear by status then data read.
// - Transfer only after stop bit, and only when data register not full.
// - Start confirmed by samples at phases 3, 5 and 7, two low.
// - Bit level is majority of samples at phases 8, 9 and 10.
// - While framing error set, completed characters are not transferred.
package asrx_pkg;
  localparam int DIV_W = 13;
  localparam int HIGH_W = 5;
  localparam logic [7:0] OFF_DIV_HIGH = 8'h00;
  localparam logic [7:0] OFF_DIV_LOW = 8'h04;
  localparam logic [7:0] OFF_CTRL = 8'h08;
  localparam logic [7:0] OFF_STATUS = 8'h0c;
  localparam logic [7:0] OFF_DATA = 8'h10;
  localparam logic [7:0] OFF_CTRL3 = 8'h14;
  localparam logic [4:0] DIV_HIGH_RST = 5'h00;
  localparam logic [7:0] DIV_LOW_RST = 8'h04;
  localparam logic [5:0] CTRL_RST = 6'h00;
  // Control register bit positions
  localparam int CTL_RX_ON = 0;
  localparam int CTL_TX_ON = 1;
  localparam int CTL_NINE = 2;
  localparam int CTL_PAR_EN = 3;
  localparam int CTL_PAR_ODD = 4;
  localparam int CTL_IDLE_SEL = 5;
  // Status register bit positions
  localparam int ST_FULL = 5;
  localparam int ST_IDLE = 4;
  localparam int ST_OVR = 3;
  localparam int ST_NF = 2;
  localparam int ST_FE = 1;
  localparam int ST_PF = 0;
  localparam logic [5:0] ARM_ALWAYS = 6'h05;
  localparam int C3_NINTH = 7;
  // Sixteenth-bit sample phases
  localparam logic [4:0] RT_FIRST = 5'h01;
  localparam logic [4:0] RT_START_A = 5'h03;
  localparam logic [4:0] RT_START_B = 5'h05;
  localparam logic [4:0] RT_START_C = 5'h07;
  localparam logic [4:0] RT_VOTE_A = 5'h08;
  localparam logic [4:0] RT_VOTE_B = 5'h09;
  localparam logic [4:0] RT_VOTE_C = 5'h0a;
  localparam logic [4:0] RT_LAST = 5'h10;
  localparam int OVERSAMPLE = 16;
  localparam logic [3:0] DATA_BITS_SHORT = 4'h8;
  localparam logic [3:0] DATA_BITS_LONG = 4'h9;
  localparam int CHAR_BITS_SHORT = 10;
  localparam int CHAR_BITS_LONG = 11;
  localparam logic [7:0] IDLE_TICKS_SHORT = 8'(CHAR_BITS_SHORT * OVERSAMPLE);
  localparam logic [7:0] IDLE_TICKS_LONG = 8'(CHAR_BITS_LONG * OVERSAMPLE);
  typedef enum logic [2:0] {
    RX_HUNT = 3'b001,
    RX_START = 3'b010,
    RX_FRAME = 3'b100
  } asrx_rx_state_type;
endpackage

// file: rtl/asrx_baud_if.sv
// Carrier between the register logic and the baud generator.
// Assumes both ends run on the bus clock.
`timescale 1ns/1ps
interface asrx_baud_if;
  logic [asrx_pkg::DIV_W-1:0] divisor;
  logic run;
  logic restart;
  logic tick;
  modport gen (input divisor, input run, input restart, output tick);
  modport user (output divisor, output run, output restart, input tick);
endinterface

// file: rtl/asrx_baud_gen.sv
// Baud generator: one-cycle sixteen-times oversampling tick.
// Assumes an asynchronous active-low reset already released cleanly.
`timescale 1ns/1ps
module asrx_baud_gen (
  input wire logic clk_in,
  input wire logic rst_n_in,
  asrx_baud_if.gen baud_bus
);
  logic [asrx_pkg::DIV_W-1:0] cnt_ff;
  logic [asrx_pkg::DIV_W-1:0] nxt_cnt;
  logic tick_ff;
  logic nxt_tick;
  logic active;

  assign active = baud_bus.run && (baud_bus.divisor != '0);
  assign baud_bus.tick = tick_ff;

  always_comb begin
    nxt_cnt = cnt_ff;
    nxt_tick = 1'b0;
    if (baud_bus.restart || !active) begin
      nxt_cnt = '0;
    end else if (cnt_ff == baud_bus.divisor - 1'b1) begin
      nxt_cnt = '0;
      nxt_tick = 1'b1;
    end else begin
      nxt_cnt = cnt_ff + 1'b1;
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      cnt_ff <= '0;
      tick_ff <= 1'b0;
    end else begin
      cnt_ff <= nxt_cnt;
      tick_ff <= nxt_tick;
    end
  end

  // Helper: cycles since the last tick, valid only after an undisturbed tick
  logic [asrx_pkg::DIV_W-1:0] since_ff;
  logic since_ok_ff;
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      since_ff <= '0;
      since_ok_ff <= 1'b0;
    end else if (baud_bus.restart || !active) begin
      since_ff <= '0;
      since_ok_ff <= 1'b0;
    end else if (tick_ff) begin
      since_ff <= '0;
      since_ok_ff <= 1'b1;
    end else begin
      since_ff <= since_ff + 1'b1;
    end
  end

  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rst_n_in);

  AST_ZERO_STOPS: assert property (
    baud_bus.divisor == '0 |=> !tick_ff [*4])
    else $error("tick while divisor is zero");
  AST_NOT_STARTED: assert property (
    !baud_bus.run |=> !tick_ff)
    else $error("tick before generator enabled");
  AST_PERIOD: assert property (
    tick_ff && since_ok_ff && $stable(baud_bus.divisor)
      |-> since_ff == baud_bus.divisor - 1'b1)
    else $error("tick period differs from divisor");
  AST_RESTART: assert property (
    baud_bus.restart && baud_bus.divisor > 13'h0001 |=> ##1 !tick_ff)
    else $error("tick too soon after new divisor");
endmodule // asrx_baud_gen

// file: rtl/asrx_rx_top.sv
// Serial receiver with baud divisor and receive status, APB slave.
// Assumes rx_in synchronous to mclk_in; zero wait-state answer after setup.
//
// The register offsets and the APB register port were left to the implementer.
`timescale 1ns/1ps
module asrx_rx_top (
  input wire logic mclk_in,
  input wire logic rst_n_in,
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [7:0] paddr_in,
  input wire logic [31:0] pwdata_in,
  input wire logic rx_in,
  output logic [31:0] prdata_out,
  output logic pready_out,
  output logic pslverr_out
);
  logic [1:0] rst_sync_ff;
  logic rst_n;

  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      rst_sync_ff <= 2'b00;
    end else begin
      rst_sync_ff <= {rst_sync_ff[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_ff[1];

  // Register state
  logic [4:0] div_high_ff, nxt_div_high;
  logic [12:0] div_work_ff, nxt_div_work;
  logic [5:0] ctrl_ff, nxt_ctrl;
  logic started_ff, nxt_started;
  logic restart_ff, nxt_restart;
  logic [31:0] prdata_ff, nxt_prdata;
  logic pready_ff, nxt_pready;
  logic pslverr_ff, nxt_pslverr;
  // Receive data and flags
  logic [7:0] data_ff, nxt_data;
  logic ninth_ff, nxt_ninth;
  logic [5:0] flags_ff, nxt_flags;
  logic [5:0] arm_ff, nxt_arm;
  logic rd_data_ff, nxt_rd_data;
  logic rd_c3_ff, nxt_rd_c3;
  logic idle_allow_ff, nxt_idle_allow;
  // Receiver
  asrx_pkg::asrx_rx_state_type state_ff, nxt_state;
  logic [4:0] rt_ff, nxt_rt;
  logic [3:0] idx_ff, nxt_idx;
  logic [2:0] hist_ff, nxt_hist;
  logic [1:0] samp_ff, nxt_samp;
  logic noise_ff, nxt_noise;
  logic [8:0] shreg_ff, nxt_shreg;
  logic [7:0] icnt_ff, nxt_icnt;

  logic tick;
  logic setup, done, mapped, wr_done;
  logic status_rd, data_rd, c3_rd;
  logic xfer, xfer_fe, idle_hit, accept, overrun, full_done;
  logic vote, nine, par_err;
  logic [3:0] nbits;
  logic [7:0] thresh;
  logic [5:0] clr, set;

  asrx_baud_if bif ();
  assign bif.divisor = div_work_ff;
  assign bif.run = started_ff;
  assign bif.restart = restart_ff;
  assign tick = bif.tick;

  asrx_baud_gen u_baud (
    .clk_in(mclk_in),
    .rst_n_in(rst_n),
    .baud_bus(bif.gen)
  );

  function automatic logic maj3(input logic a, input logic b, input logic c);
    maj3 = (a & b) | (a & c) | (b & c);
  endfunction

  assign setup = psel_in && !penable_in;
  assign done = psel_in && penable_in && pready_ff;
  assign wr_done = done && pwrite_in && !pslverr_ff;
  assign status_rd = done && !pwrite_in && paddr_in == asrx_pkg::OFF_STATUS;
  assign data_rd = done && !pwrite_in && paddr_in == asrx_pkg::OFF_DATA;
  assign c3_rd = done && !pwrite_in && paddr_in == asrx_pkg::OFF_CTRL3;
  assign mapped = paddr_in == asrx_pkg::OFF_DIV_HIGH
    || paddr_in == asrx_pkg::OFF_DIV_LOW || paddr_in == asrx_pkg::OFF_CTRL
    || paddr_in == asrx_pkg::OFF_STATUS || paddr_in == asrx_pkg::OFF_DATA
    || paddr_in == asrx_pkg::OFF_CTRL3;
  assign nine = ctrl_ff[asrx_pkg::CTL_NINE];
  assign nbits = nine ? asrx_pkg::DATA_BITS_LONG : asrx_pkg::DATA_BITS_SHORT;
  assign thresh = nine ? asrx_pkg::IDLE_TICKS_LONG
                       : asrx_pkg::IDLE_TICKS_SHORT;

  // Bus slave and configuration
  always_comb begin
    nxt_div_high = div_high_ff;
    nxt_div_work = div_work_ff;
    nxt_ctrl = ctrl_ff;
    nxt_started = started_ff;
    nxt_restart = 1'b0;
    nxt_pready = setup;
    nxt_pslverr = setup && !mapped;
    nxt_prdata = 32'h0000_0000;
    if (setup && !pwrite_in) begin
      unique case (paddr_in)
        asrx_pkg::OFF_DIV_HIGH: nxt_prdata = {27'h0, div_high_ff};
        asrx_pkg::OFF_DIV_LOW: nxt_prdata = {24'h0, div_work_ff[7:0]};
        asrx_pkg::OFF_CTRL: nxt_prdata = {26'h0, ctrl_ff};
        asrx_pkg::OFF_STATUS: nxt_prdata = {26'h0, flags_ff};
        asrx_pkg::OFF_DATA: nxt_prdata = {24'h0, data_ff};
        asrx_pkg::OFF_CTRL3: nxt_prdata = {24'h0, ninth_ff, 7'h00};
        default: nxt_prdata = 32'h0000_0000;
      endcase
    end else if (pready_ff && !done) begin
      nxt_prdata = prdata_ff;
      nxt_pready = 1'b1;
      nxt_pslverr = pslverr_ff;
    end
    if (wr_done) begin
      unique case (paddr_in)
        asrx_pkg::OFF_DIV_HIGH: nxt_div_high = pwdata_in[4:0];
        asrx_pkg::OFF_DIV_LOW: begin
          nxt_div_work = {div_high_ff, pwdata_in[7:0]};
          nxt_restart = 1'b1;
        end
        asrx_pkg::OFF_CTRL: begin
          nxt_ctrl = pwdata_in[5:0];
          if (pwdata_in[asrx_pkg::CTL_RX_ON] || pwdata_in[asrx_pkg::CTL_TX_ON]) begin
            nxt_started = 1'b1;
          end
        end
        default: nxt_ctrl = ctrl_ff;
      endcase
    end
  end

  always_ff @(posedge mclk_in or negedge rst_n) begin
    if (!rst_n) begin
      div_high_ff <= asrx_pkg::DIV_HIGH_RST;
      div_work_ff <= {asrx_pkg::DIV_HIGH_RST, asrx_pkg::DIV_LOW_RST};
      ctrl_ff <= asrx_pkg::CTRL_RST;
      started_ff <= 1'b0;
      restart_ff <= 1'b0;
      prdata_ff <= 32'h0000_0000;
      pready_ff <= 1'b0;
      pslverr_ff <= 1'b0;
    end else begin
      div_high_ff <= nxt_div_high;
      div_work_ff <= nxt_div_work;
      ctrl_ff <= nxt_ctrl;
      started_ff <= nxt_started;
      restart_ff <= nxt_restart;
      prdata_ff <= nxt_prdata;
      pready_ff <= nxt_pready;
      pslverr_ff <= nxt_pslverr;
    end
  end
  assign prdata_out = prdata_ff;
  assign pready_out = pready_ff;
  assign pslverr_out = pslverr_ff;

  // Receiver sampling, framing and idle counting
  always_comb begin
    nxt_state = state_ff;
    nxt_rt = rt_ff;
    nxt_idx = idx_ff;
    nxt_hist = hist_ff;
    nxt_samp = samp_ff;
    nxt_noise = noise_ff;
    nxt_shreg = shreg_ff;
    nxt_icnt = icnt_ff;
    xfer = 1'b0;
    xfer_fe = 1'b0;
    vote = maj3(samp_ff[1], samp_ff[0], rx_in);
    if (!ctrl_ff[asrx_pkg::CTL_RX_ON]) begin
      nxt_state = asrx_pkg::RX_HUNT;
      nxt_hist = 3'b000;
      nxt_icnt = 8'h00;
    end else if (tick) begin
      if (rt_ff == asrx_pkg::RT_START_A || rt_ff == asrx_pkg::RT_START_B
          || rt_ff == asrx_pkg::RT_VOTE_A || rt_ff == asrx_pkg::RT_VOTE_B) begin
        nxt_samp = {samp_ff[0], rx_in};
      end
      nxt_rt = (rt_ff == asrx_pkg::RT_LAST) ? asrx_pkg::RT_FIRST
                                            : rt_ff + 5'h01;
      unique case (state_ff)
        asrx_pkg::RX_HUNT: begin
          nxt_hist = {hist_ff[1:0], rx_in};
          if (hist_ff == 3'b111 && !rx_in) begin
            nxt_state = asrx_pkg::RX_START;
            nxt_rt = asrx_pkg::RT_FIRST + 5'h01;
            nxt_noise = 1'b0;
          end
        end
        asrx_pkg::RX_START: begin
          if (rx_in && rt_ff >= asrx_pkg::RT_START_A
              && rt_ff <= asrx_pkg::RT_VOTE_C && rt_ff[0] | rt_ff[3]) begin
            nxt_noise = 1'b1;
          end
          if (rt_ff == asrx_pkg::RT_START_C && vote) begin
            nxt_state = asrx_pkg::RX_HUNT;
            nxt_hist = 3'b000;
          end else if (rt_ff == asrx_pkg::RT_LAST) begin
            nxt_state = asrx_pkg::RX_FRAME;
            nxt_idx = 4'h0;
          end
        end
        asrx_pkg::RX_FRAME: begin
          if (rt_ff == asrx_pkg::RT_VOTE_C) begin
            if (samp_ff[1] != samp_ff[0] || samp_ff[0] != rx_in) begin
              nxt_noise = 1'b1;
            end
            if (idx_ff == nbits) begin
              xfer = 1'b1;
              xfer_fe = !vote;
              nxt_state = asrx_pkg::RX_HUNT;
              nxt_hist = (!vote && shreg_ff == 9'h000) ? 3'b000 : 3'b111;
            end else begin
              nxt_shreg[idx_ff] = vote;
            end
          end
          if (rt_ff == asrx_pkg::RT_LAST) begin
            nxt_idx = idx_ff + 4'h1;
          end
        end
        default: nxt_state = asrx_pkg::RX_HUNT;
      endcase
      if (rx_in && (state_ff == asrx_pkg::RX_HUNT
          || (state_ff == asrx_pkg::RX_FRAME
              && !ctrl_ff[asrx_pkg::CTL_IDLE_SEL]))) begin
        nxt_icnt = (icnt_ff == thresh) ? icnt_ff : icnt_ff + 8'h01;
      end else begin
        nxt_icnt = 8'h00;
      end
    end
  end
  assign idle_hit = nxt_icnt == thresh && icnt_ff != thresh;
  assign par_err = ctrl_ff[asrx_pkg::CTL_PAR_EN]
    && ((nine ? ^shreg_ff[8:0] : ^shreg_ff[7:0])
        ^ ctrl_ff[asrx_pkg::CTL_PAR_ODD]);

  always_ff @(posedge mclk_in or negedge rst_n) begin
    if (!rst_n) begin
      state_ff <= asrx_pkg::RX_HUNT;
      rt_ff <= asrx_pkg::RT_FIRST;
      idx_ff <= 4'h0;
      hist_ff <= 3'b000;
      samp_ff <= 2'b00;
      noise_ff <= 1'b0;
      shreg_ff <= 9'h000;
      icnt_ff <= 8'h00;
    end else begin
      state_ff <= nxt_state;
      rt_ff <= nxt_rt;
      idx_ff <= nxt_idx;
      hist_ff <= nxt_hist;
      samp_ff <= nxt_samp;
      noise_ff <= nxt_noise;
      shreg_ff <= nxt_shreg;
      icnt_ff <= nxt_icnt;
    end
  end

  // Status flags, two-step clearing and data buffer
  assign overrun = xfer && flags_ff[asrx_pkg::ST_FULL]
    && !flags_ff[asrx_pkg::ST_FE];
  assign accept = xfer && !flags_ff[asrx_pkg::ST_FULL]
    && !flags_ff[asrx_pkg::ST_FE];
  assign full_done = arm_ff[asrx_pkg::ST_FULL]
    && ((data_rd && (!nine || rd_c3_ff))
        || (c3_rd && nine && rd_data_ff));

  always_comb begin
    clr = 6'h00;
    set = 6'h00;
    nxt_data = data_ff;
    nxt_ninth = ninth_ff;
    nxt_arm = arm_ff;
    nxt_rd_data = rd_data_ff;
    nxt_rd_c3 = rd_c3_ff;
    nxt_idle_allow = idle_allow_ff;
    if (data_rd) begin
      clr = arm_ff;
      clr[asrx_pkg::ST_FULL] = 1'b0;
      nxt_rd_data = arm_ff[asrx_pkg::ST_FULL];
    end
    if (c3_rd) begin
      nxt_rd_c3 = arm_ff[asrx_pkg::ST_FULL];
    end
    if (full_done) begin
      clr[asrx_pkg::ST_FULL] = 1'b1;
      nxt_rd_data = 1'b0;
      nxt_rd_c3 = 1'b0;
    end
    nxt_arm = arm_ff & ~clr;
    if (status_rd) begin
      nxt_arm = prdata_ff[5:0] | asrx_pkg::ARM_ALWAYS;
      nxt_rd_data = 1'b0;
      nxt_rd_c3 = 1'b0;
    end
    if (accept) begin
      set[asrx_pkg::ST_FULL] = 1'b1;
      set[asrx_pkg::ST_NF] = nxt_noise;
      set[asrx_pkg::ST_FE] = xfer_fe;
      set[asrx_pkg::ST_PF] = par_err;
      nxt_data = shreg_ff[7:0];
      nxt_ninth = shreg_ff[8];
      nxt_idle_allow = 1'b1;
    end
    if (overrun) begin
      set[asrx_pkg::ST_OVR] = 1'b1;
    end
    if (idle_hit && idle_allow_ff && !accept) begin
      set[asrx_pkg::ST_IDLE] = 1'b1;
      nxt_idle_allow = 1'b0;
    end
    nxt_flags = (flags_ff & ~clr) | set;
  end

  always_ff @(posedge mclk_in or negedge rst_n) begin
    if (!rst_n) begin
      data_ff <= 8'h00;
      ninth_ff <= 1'b0;
      flags_ff <= 6'h00;
      arm_ff <= 6'h00;
      rd_data_ff <= 1'b0;
      rd_c3_ff <= 1'b0;
      idle_allow_ff <= 1'b0;
    end else begin
      data_ff <= nxt_data;
      ninth_ff <= nxt_ninth;
      flags_ff <= nxt_flags;
      arm_ff <= nxt_arm;
      rd_data_ff <= nxt_rd_data;
      rd_c3_ff <= nxt_rd_c3;
      idle_allow_ff <= nxt_idle_allow;
    end
  end

  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (!rst_n);

  AST_HIGH_BUFFERED: assert property (
    wr_done && paddr_in == asrx_pkg::OFF_DIV_HIGH |=> $stable(div_work_ff))
    else $error("high divisor write changed working divisor");
  AST_LOW_LOADS: assert property (
    wr_done && paddr_in == asrx_pkg::OFF_DIV_LOW
      |=> div_work_ff == {$past(div_high_ff), $past(pwdata_in[7:0])})
    else $error("low divisor write did not load both halves");
  AST_FULL_SET: assert property (
    accept |=> flags_ff[asrx_pkg::ST_FULL] && data_ff == $past(shreg_ff[7:0]))
    else $error("accepted character not in data register");
  AST_OVERRUN: assert property (
    overrun |=> flags_ff[asrx_pkg::ST_OVR] && $stable(data_ff))
    else $error("overrun not flagged or data overwritten");
  AST_FE_BLOCKS: assert property (
    xfer && flags_ff[asrx_pkg::ST_FE] |=> $stable(data_ff))
    else $error("character moved while framing error set");
  AST_FE_WITH_FULL: assert property (
    $rose(flags_ff[asrx_pkg::ST_FE]) |-> $rose(flags_ff[asrx_pkg::ST_FULL]))
    else $error("framing error set without full");
  AST_NF_WITH_FULL: assert property (
    $rose(flags_ff[asrx_pkg::ST_NF]) |-> $rose(flags_ff[asrx_pkg::ST_FULL]))
    else $error("noise set without full");
  AST_PF_WITH_FULL: assert property (
    $rose(flags_ff[asrx_pkg::ST_PF]) |-> $rose(flags_ff[asrx_pkg::ST_FULL]))
    else $error("parity error set without full");
  AST_IDLE_ONCE: assert property (
    $rose(flags_ff[asrx_pkg::ST_IDLE]) |-> $past(idle_allow_ff)
      && !idle_allow_ff && icnt_ff == thresh)
    else $error("idle set without new character or full time");
  AST_NINE_HOLD: assert property (
    nine && data_rd && !rd_c3_ff && !accept |=> flags_ff[asrx_pkg::ST_FULL]
      == $past(flags_ff[asrx_pkg::ST_FULL]))
    else $error("full cleared before control three read");

  COV_RECEIVE: cover property (accept && !par_err && !xfer_fe);
  COV_OVERRUN: cover property (overrun);
  COV_IDLE: cover property ($rose(flags_ff[asrx_pkg::ST_IDLE]));
  COV_FULL_CLEAR: cover property (full_done);
endmodule // asrx_rx_top

// file: testbench/asrx_tx_model.sv
// Remote serial transmitter model driving the receive line.
// Assumes the bench calls send; the line idles high as with a pull-up.
`timescale 1ns/1ps
module asrx_tx_model (
  input wire logic clk_in,
  output logic line_out
);
  initial line_out = 1'b1;
  // Idle bit, start, data LSB first, stop; glitch flips one tick
  task automatic send(input logic [8:0] val, input int nbits,
      input int div, input logic stop, input int glitch);
    logic b;
    for (int i = 0; i < nbits + 3; i++) begin
      b = (i == 0) ? 1'b1 : (i == 1) ? 1'b0 : val[i - 2];
      if (i == nbits + 2) b = stop;
      for (int j = 0; j < 16 * div; j++) begin
        @(posedge clk_in);
        line_out <= (i == glitch && j / div == 8) ? ~b : b;
      end
    end
    @(posedge clk_in);
    line_out <= 1'b1;
  endtask
endmodule // asrx_tx_model

// file: testbench/async_serial_receiver_baud_tb.sv
// Self-checking bench of the serial receiver over APB.
// Assumes the design answers each APB access within a few cycles.
`timescale 1ns/1ps
module async_serial_receiver_baud_tb;
  logic mclk_in, rst_n_in, psel, penable, pwrite, rx, pready, pslverr, e;
  logic [7:0] paddr, p;
  logic [31:0] pwdata, prdata, q;
  logic [8:0] d;
  int fail_count, num_checks, seed, div;
  asrx_rx_top dut (.mclk_in(mclk_in), .rst_n_in(rst_n_in),
    .psel_in(psel), .penable_in(penable), .pwrite_in(pwrite),
    .paddr_in(paddr), .pwdata_in(pwdata), .rx_in(rx),
    .prdata_out(prdata), .pready_out(pready), .pslverr_out(pslverr));
  asrx_tx_model tx (.clk_in(mclk_in), .line_out(rx));
  initial begin
    mclk_in = 1'b0;
    forever #20 mclk_in = ~mclk_in;
  end
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic wr, input logic [7:0] a,
      input logic [31:0] wd);
    @(posedge mclk_in);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge mclk_in);
    penable <= 1'b1;
    do begin
      @(posedge mclk_in);
    end while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(q, exp);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] wd);
    apb(1'b1, a, wd);
  endtask
  task automatic bits(input int n);
    repeat (n * 16 * div) @(posedge mclk_in);
  endtask
  // Status word from {full, idle, overrun, noise, framing, parity}
  function automatic logic [31:0] st(input logic [5:0] f);
    st = 32'h0;
    st[asrx_pkg::ST_FULL] = f[5];
    st[asrx_pkg::ST_IDLE] = f[4];
    st[asrx_pkg::ST_OVR] = f[3];
    st[asrx_pkg::ST_NF] = f[2];
    st[asrx_pkg::ST_FE] = f[1];
    st[asrx_pkg::ST_PF] = f[0];
  endfunction
  initial begin
    #2_000_000;
    fail_count++;
    report_and_stop();
  end
  initial begin
    {psel, penable, pwrite, paddr, pwdata} = '0;
    rst_n_in = 1'b0;
    seed = 45631;
    div = 1;
    repeat (5) @(posedge mclk_in);
    rst_n_in <= 1'b1;
    repeat (3) @(posedge mclk_in);
    rd(asrx_pkg::OFF_DIV_LOW, 32'h4);
    rd(asrx_pkg::OFF_STATUS, 32'h0);
    apb(1'b0, 8'h18, 32'h0);
    chk({31'h0, e}, 32'h1);
    wr(asrx_pkg::OFF_DIV_LOW, 32'h1);
    wr(asrx_pkg::OFF_CTRL, 32'h1);
    wr(asrx_pkg::OFF_DIV_HIGH, 32'h1);
    rd(asrx_pkg::OFF_DIV_HIGH, 32'h1);
    for (int i = 0; i < 6; i++) begin
      if (i == 3) begin
        wr(asrx_pkg::OFF_DIV_HIGH, 32'h0);
        wr(asrx_pkg::OFF_DIV_LOW, 32'h2);
        div = 2;
      end
      d = 9'($random(seed));
      // An all-ones byte would reach idle before the next start bit
      if (d[7:0] == 8'hff) d[7] = 1'b0;
      tx.send(d, 8, div, 1'b1, -1);
      rd(asrx_pkg::OFF_STATUS, st(6'h20));
      rd(asrx_pkg::OFF_DATA, {24'h0, d[7:0]});
    end
    bits(12);
    rd(asrx_pkg::OFF_STATUS, st(6'h10));
    rd(asrx_pkg::OFF_DATA, {24'h0, d[7:0]});
    bits(12);
    rd(asrx_pkg::OFF_STATUS, st(6'h00));
    tx.send(9'h0ff, 8, div, 1'b1, -1);
    bits(5);
    rd(asrx_pkg::OFF_STATUS, st(6'h30));
    rd(asrx_pkg::OFF_DATA, 32'hff);
    wr(asrx_pkg::OFF_CTRL, 32'h21);
    tx.send(9'h0ff, 8, div, 1'b1, -1);
    bits(5);
    rd(asrx_pkg::OFF_STATUS, st(6'h20));
    rd(asrx_pkg::OFF_DATA, 32'hff);
    bits(12);
    rd(asrx_pkg::OFF_STATUS, st(6'h10));
    rd(asrx_pkg::OFF_DATA, 32'hff);
    wr(asrx_pkg::OFF_CTRL, 32'h1);
    tx.send(9'h0a6, 8, div, 1'b1, 5);
    rd(asrx_pkg::OFF_STATUS, st(6'h24));
    rd(asrx_pkg::OFF_DATA, 32'ha6);
    wr(asrx_pkg::OFF_CTRL, 32'h9);
    for (int k = 0; k < 4; k++) begin
      p = (k == 0) ? 8'h01 : 8'($random(seed));
      if (p == 8'hff) p = 8'h7f;
      tx.send({1'b0, p}, 8, div, 1'b1, -1);
      rd(asrx_pkg::OFF_STATUS, st({5'h10, ^p}));
      rd(asrx_pkg::OFF_DATA, {24'h0, p});
      rd(asrx_pkg::OFF_STATUS, st(6'h00));
    end
    // Idle count after stop only: the false start after a low stop bit
    // runs over quiet line and must not raise idle
    wr(asrx_pkg::OFF_CTRL, 32'h21);
    tx.send(9'h055, 8, div, 1'b0, -1);
    rd(asrx_pkg::OFF_STATUS, st(6'h22));
    bits(10);
    tx.send(9'h033, 8, div, 1'b1, -1);
    rd(asrx_pkg::OFF_STATUS, st(6'h22));
    rd(asrx_pkg::OFF_DATA, 32'h55);
    rd(asrx_pkg::OFF_STATUS, st(6'h00));
    wr(asrx_pkg::OFF_CTRL, 32'h5);
    tx.send(9'h1a5, 9, div, 1'b1, -1);
    rd(asrx_pkg::OFF_STATUS, st(6'h20));
    rd(asrx_pkg::OFF_DATA, 32'ha5);
    tx.send(9'h0f0, 9, div, 1'b1, -1);
    rd(asrx_pkg::OFF_STATUS, st(6'h28));
    rd(asrx_pkg::OFF_CTRL3, 32'h80);
    rd(asrx_pkg::OFF_DATA, 32'ha5);
    rd(asrx_pkg::OFF_STATUS, st(6'h00));
    wr(asrx_pkg::OFF_DIV_LOW, 32'h0);
    tx.send(9'h0aa, 8, div, 1'b1, -1);
    rd(asrx_pkg::OFF_STATUS, st(6'h00));
    report_and_stop();
  end
endmodule // async_serial_receiver_baud_tb
